// File: hdl/tick_accum.sv
/*
 * Periodic tick generator and 8-bit pulse accumulator with APB registers.
 * Assumes pclk is the E clock and the accumulator pin is asynchronous to it.
 */
`timescale 1ns/1ps
module tick_accum
	import tick_accum_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic accum_input_pin,
	input wire logic main_timer_wrap,
	output logic irq_req,
	output logic capture_channel_four,
	output logic compare_channel_five
);

	/********************************************************************
	 * Bus decode
	 ********************************************************************/
	logic [7:0] mask_r;
	logic [7:0] flags_r;
	logic [7:0] ctrl_r;
	logic [7:0] count_r;
	logic [7:0] flags_nxt;
	logic [7:0] count_nxt;

	wire logic [9:0] word_idx = paddr[11:2];
	wire logic hit_mask = word_idx == {2'h0, IDX_MASK};
	wire logic hit_flags = word_idx == {2'h0, IDX_FLAGS};
	wire logic hit_ctrl = word_idx == {2'h0, IDX_CTRL};
	wire logic hit_count = word_idx == {2'h0, IDX_COUNT};
	wire logic hit_any = hit_mask | hit_flags | hit_ctrl | hit_count;
	wire logic access = psel & penable;
	wire logic wr_lane = pstrb[0];
	wire logic wr_mask = access & pwrite & wr_lane & hit_mask;
	wire logic wr_flags = access & pwrite & wr_lane & hit_flags;
	wire logic wr_ctrl = access & pwrite & wr_lane & hit_ctrl;
	wire logic wr_count = access & pwrite & wr_lane & hit_count;
	// Read data is sampled in the setup cycle so it stands stable through access.
	wire logic rd_setup = psel & ~penable & ~pwrite;

	wire logic [7:0] rd_mux = hit_mask ? (mask_r & MASK_IMPL) :
		hit_flags ? (flags_r & FLAGS_IMPL) :
		hit_ctrl ? (ctrl_r & CTRL_IMPL) :
		hit_count ? count_r : 8'h00;

	/********************************************************************
	 * Pin synchroniser and edge detect
	 ********************************************************************/
	logic pin_s1_r;
	logic pin_s2_r;
	logic pin_d_r;

	wire logic edge_lvl = ctrl_r[BIT_ACC_EDGE_LVL];
	wire logic rise = pin_s2_r & ~pin_d_r;
	wire logic fall = ~pin_s2_r & pin_d_r;
	wire logic sel_edge = edge_lvl ? rise : fall;
	// Active level for gating: inhibit on zero when edge bit 0, on one when 1.
	wire logic gate_active = edge_lvl ? ~pin_s2_r : pin_s2_r;

	/********************************************************************
	 * Dividers
	 ********************************************************************/
	logic [TICK_DIV_W-1:0] tick_div_r;
	logic [GATE_DIV_LOG2-1:0] gate_div_r;

	wire logic [1:0] rate = {ctrl_r[BIT_RATE_HI], ctrl_r[BIT_RATE_LO]};
	wire logic [TICK_DIV_W-1:0] tick_mask =
		TICK_DIV_W'((32'h1 << (TICK_BASE_LOG2 + int'(rate))) - 32'h1);
	// Divider never stops, so the period runs from timeout to timeout.
	wire logic tick = (tick_div_r & tick_mask) == tick_mask;
	wire logic gate_tick = &gate_div_r;

	/********************************************************************
	 * Accumulator
	 ********************************************************************/
	wire logic acc_en = ctrl_r[BIT_ACC_EN];
	wire logic gated = ctrl_r[BIT_ACC_GATED];
	wire logic acc_inc = acc_en & (gated ? (gate_tick & gate_active) : sel_edge);
	wire logic acc_wrap = acc_inc & ~wr_count & (count_r == 8'hff);
	wire logic edge_evt = acc_en & sel_edge;

	always_comb begin
		count_nxt = count_r;
		if (wr_count) begin
			count_nxt = pwdata[7:0];
		end else if (acc_inc) begin
			count_nxt = 8'(count_r + 8'h01);
		end
	end

	always_comb begin
		flags_nxt = flags_r;
		if (wr_flags) begin
			flags_nxt = flags_r & ~(pwdata[7:0] & FLAGS_IMPL);
		end
		if (main_timer_wrap) begin
			flags_nxt[BIT_MAIN_OVF] = 1'b1;
		end
		if (tick) begin
			flags_nxt[BIT_TICK] = 1'b1;
		end
		if (acc_wrap) begin
			flags_nxt[BIT_ACC_OVF] = 1'b1;
		end
		if (edge_evt) begin
			flags_nxt[BIT_ACC_EDGE] = 1'b1;
		end
	end

	/********************************************************************
	 * Registers
	 ********************************************************************/
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_r <= 1'b0;
			pin_s2_r <= 1'b0;
			pin_d_r <= 1'b0;
			tick_div_r <= '0;
			gate_div_r <= '0;
		end else begin
			pin_s1_r <= accum_input_pin;
			pin_s2_r <= pin_s1_r;
			pin_d_r <= pin_s2_r;
			tick_div_r <= TICK_DIV_W'(tick_div_r + 1'b1);
			gate_div_r <= GATE_DIV_LOG2'(gate_div_r + 1'b1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_r <= MASK_RESET;
			flags_r <= FLAGS_RESET;
			ctrl_r <= CTRL_RESET;
		end else begin
			if (wr_mask) begin
				mask_r <= pwdata[7:0] & MASK_IMPL;
			end
			if (wr_ctrl) begin
				ctrl_r <= pwdata[7:0] & CTRL_IMPL;
			end
			flags_r <= flags_nxt;
		end
	end

	// The count has no reset so it keeps its value across reset.
	always_ff @(posedge pclk) begin
		count_r <= count_nxt;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			irq_req <= 1'b0;
			capture_channel_four <= 1'b0;
			compare_channel_five <= 1'b1;
		end else begin
			if (rd_setup) begin
				prdata <= {24'h000000, rd_mux};
			end
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~hit_any;
			irq_req <= |(flags_nxt & mask_r & FLAGS_IMPL);
			capture_channel_four <= ctrl_r[BIT_CH_SEL];
			compare_channel_five <= ~ctrl_r[BIT_CH_SEL];
		end
	end

	/********************************************************************
	 * Assertions
	 ********************************************************************/
	// The count has no reset, so it is unknown until software first writes it.
	// Checks that compare the count with its past value wait for that write so they never judge an unknown value.
	logic count_loaded_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_loaded_r <= 1'b0;
		end else if (wr_count) begin
			count_loaded_r <= 1'b1;
		end
	end

	property p_tick_sets_flag;
		@(posedge pclk) disable iff (!presetn) tick |=> flags_r[BIT_TICK];
	endproperty
	a_tick_sets_flag: assert property (p_tick_sets_flag) else $error("tick flag not set");

	property p_first_tick;
		@(posedge pclk) disable iff (!presetn)
			$rose(presetn) |-> !flags_r[BIT_TICK] [*8];
	endproperty
	a_first_tick: assert property (p_first_tick) else $error("tick flag early");

	property p_w1c;
		@(posedge pclk) disable iff (!presetn)
			wr_flags && pwdata[BIT_TICK] && !tick |=> !flags_r[BIT_TICK];
	endproperty
	a_w1c: assert property (p_w1c) else $error("flag not cleared");

	property p_set_wins;
		@(posedge pclk) disable iff (!presetn)
			wr_flags && edge_evt |=> flags_r[BIT_ACC_EDGE];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("set lost to clear");

	property p_irq;
		@(posedge pclk) disable iff (!presetn)
			irq_req |-> |($past(flags_nxt) & $past(mask_r) & FLAGS_IMPL);
	endproperty
	a_irq: assert property (p_irq) else $error("spurious irq");

	property p_disabled;
		@(posedge pclk) disable iff (!presetn)
			count_loaded_r && !acc_en && !wr_count |=> count_r == $past(count_r);
	endproperty
	a_disabled: assert property (p_disabled) else $error("count moved while off");

	property p_wrap;
		@(posedge pclk) disable iff (!presetn)
			acc_inc && !wr_count && count_r == 8'hff |=> count_r == 8'h00 && flags_r[BIT_ACC_OVF];
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap wrong");

	property p_event_inc;
		@(posedge pclk) disable iff (!presetn)
			count_loaded_r && acc_en && !gated && sel_edge && !wr_count
			|=> count_r == 8'($past(count_r) + 8'h01);
	endproperty
	a_event_inc: assert property (p_event_inc) else $error("edge not counted");

	property p_gated_hold;
		@(posedge pclk) disable iff (!presetn)
			count_loaded_r && gated && !(gate_tick && gate_active) && !wr_count
			|=> count_r == $past(count_r);
	endproperty
	a_gated_hold: assert property (p_gated_hold) else $error("gated count moved");

	property p_count_write;
		@(posedge pclk) disable iff (!presetn)
			wr_count |=> count_r == $past(pwdata[7:0]);
	endproperty
	a_count_write: assert property (p_count_write) else $error("count write lost");

	property p_unimpl_flags;
		@(posedge pclk) disable iff (!presetn) flags_r[3:0] == 4'h0;
	endproperty
	a_unimpl_flags: assert property (p_unimpl_flags) else $error("low flag bits set");

	property p_irq_match;
		@(posedge pclk) disable iff (!presetn)
			irq_req == |(flags_r & $past(mask_r) & FLAGS_IMPL);
	endproperty
	a_irq_match: assert property (p_irq_match) else $error("irq not flag and mask");

	property p_reserved;
		@(posedge pclk) disable iff (!presetn) prdata[31:8] == 24'h000000;
	endproperty
	a_reserved: assert property (p_reserved) else $error("upper bits set");

	property p_chsel;
		@(posedge pclk) disable iff (!presetn)
			capture_channel_four != compare_channel_five;
	endproperty
	a_chsel: assert property (p_chsel) else $error("channel select broken");

	c_tick: cover property (@(posedge pclk) disable iff (!presetn) tick);
	c_wrap: cover property (@(posedge pclk) disable iff (!presetn) acc_wrap);
	c_gated: cover property (@(posedge pclk) disable iff (!presetn) gated && acc_inc);
	c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq_req));

endmodule

// File: common/tick_accum_pkg.sv
/*
 * Constants for the periodic tick and pulse accumulator block.
 * Assumes an APB slave with 32-bit data and byte offsets held as register indexes.
 */
package tick_accum_pkg;

	// Register indexes; byte address is four times the index.
	localparam logic [7:0] IDX_MASK = 8'h24;
	localparam logic [7:0] IDX_FLAGS = 8'h25;
	localparam logic [7:0] IDX_CTRL = 8'h26;
	localparam logic [7:0] IDX_COUNT = 8'h27;

	// Field positions shared by the mask and flag registers.
	localparam int BIT_MAIN_OVF = 7;
	localparam int BIT_TICK = 6;
	localparam int BIT_ACC_OVF = 5;
	localparam int BIT_ACC_EDGE = 4;
	localparam logic [7:0] MASK_IMPL = 8'hf3;
	localparam logic [7:0] FLAGS_IMPL = 8'hf0;
	localparam logic [7:0] CTRL_IMPL = 8'h77;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Control register fields.
	localparam int BIT_ACC_EN = 6;
	localparam int BIT_ACC_GATED = 5;
	localparam int BIT_ACC_EDGE_LVL = 4;
	localparam int BIT_CH_SEL = 2;
	localparam int BIT_RATE_HI = 1;
	localparam int BIT_RATE_LO = 0;

	// Timing: tick base is 2^12 cycles, gated accumulation tick is 64 cycles.
	localparam int TICK_BASE_LOG2 = 12;
	localparam int TICK_DIV_W = 15;
	localparam int GATE_DIV_LOG2 = 6;

endpackage

// File: testbench/pulse_source.sv
/*
 * Model of the external pulse source on the accumulator input pin.
 * Assumes the bench calls its tasks from the pclk domain.
 */
`timescale 1ns/1ps
module pulse_source (
	input wire logic pclk,
	output logic pin
);
	initial pin = 1'b1;
	task automatic level(input logic v);
		@(posedge pclk);
		pin <= v;
	endtask
	// Each level is held at least three cycles, so edges stay slower than half the clock.
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge pclk);
			pin <= ~pin;
			repeat (4) @(posedge pclk);
			pin <= ~pin;
			repeat (3) @(posedge pclk);
		end
	endtask
endmodule

// File: testbench/test_periodic_tick_and_pulse_counter.sv
/*
 * Self-checking bench for the tick generator and pulse accumulator.
 * Assumes the design answers each APB access and the pin model drives the input.
 */
`timescale 1ns/1ps
module test_periodic_tick_and_pulse_counter
	import tick_accum_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic main_timer_wrap = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready, pslverr, irq_req, cap4, cmp5, pin, e;
	logic [7:0] q, d;
	int err_total = 0, checked = 0, seed = 81871, cyc = 0, t0, t1, t2, n;

	tick_accum i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .accum_input_pin(pin),
		.main_timer_wrap(main_timer_wrap), .irq_req(irq_req),
		.capture_channel_four(cap4), .compare_channel_five(cmp5));
	pulse_source i_src (.pclk(pclk), .pin(pin));

	initial forever #5 pclk = ~pclk;
	always @(posedge pclk) cyc <= cyc + 1;

	// ****************************************
	// Bus and compare tasks.
	// ****************************************
	function automatic logic [7:0] exp_count(input logic [7:0] base, input int k);
		return 8'(base + k);
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_t(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, pready, 1'b1);
		end
		q = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(q, exp);
	endtask
	task automatic wait_irq(output int t);
		int k;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (irq_req !== 1'b1 && k < 40000);
		if (irq_req !== 1'b1) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, irq_req, 1'b1);
		end
		t = cyc;
	endtask
	task automatic stop_test();
		$display("checked %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ****************************************
	// Main sequence and watchdog.
	// ****************************************
	initial begin
		repeat (100000) @(posedge pclk);
		err_total++;
		stop_test();
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t0 = cyc;
		rd(IDX_MASK, 8'h00);
		rd(IDX_CTRL, 8'h00);
		apb(1'b1, IDX_MASK, 8'h40);
		wait_irq(t1);
		chk(8'(t1 - t0 >= 4096), 8'h01);
		for (int r = 0; r < 2; r++) begin
			apb(1'b1, IDX_CTRL, 8'(r));
			apb(1'b1, IDX_FLAGS, 8'h40);
			repeat (2) @(posedge pclk);
			wait_irq(t1);
			apb(1'b1, IDX_FLAGS, 8'h40);
			repeat (2) @(posedge pclk);
			wait_irq(t2);
			chk_t(32'(t2 - t1), 32'(4096 << r));
		end
		$display("test tick done");
		apb(1'b1, IDX_MASK, 8'hff);
		rd(IDX_MASK, 8'hf3);
		apb(1'b1, IDX_CTRL, 8'hff);
		rd(IDX_CTRL, 8'h77);
		chk({6'h0, cap4, cmp5}, 8'h02);
		apb(1'b1, IDX_CTRL, 8'h00);
		repeat (2) @(posedge pclk);
		chk({6'h0, cap4, cmp5}, 8'h01);
		apb(1'b0, IDX_FLAGS, 8'h00);
		chk(q & 8'h0f, 8'h00);
		apb(1'b0, 8'h30, 8'h00);
		chk({e, q[6:0]}, 8'h80);
		d = 8'($random(seed));
		apb(1'b1, IDX_COUNT, d);
		rd(IDX_COUNT, d);
		$display("test registers done");
		apb(1'b1, IDX_MASK, 8'h00);
		apb(1'b1, IDX_FLAGS, 8'hf0);
		apb(1'b1, IDX_COUNT, 8'hfd);
		apb(1'b1, IDX_CTRL, 8'h40);
		n = 3 + ($random(seed) & 3);
		i_src.pulse(n);
		repeat (6) @(posedge pclk);
		rd(IDX_COUNT, exp_count(8'hfd, n));
		apb(1'b0, IDX_FLAGS, 8'h00);
		chk(q & 8'h30, 8'h30);
		apb(1'b1, IDX_CTRL, 8'h50);
		i_src.level(1'b0);
		apb(1'b1, IDX_COUNT, 8'h10);
		n = 1 + ($random(seed) & 7);
		i_src.pulse(n);
		repeat (6) @(posedge pclk);
		rd(IDX_COUNT, exp_count(8'h10, n));
		apb(1'b1, IDX_FLAGS, 8'h10);
		apb(1'b1, IDX_CTRL, 8'h10);
		i_src.pulse(3);
		repeat (6) @(posedge pclk);
		rd(IDX_COUNT, exp_count(8'h10, n));
		$display("test event done");
		apb(1'b1, IDX_CTRL, 8'h70);
		i_src.level(1'b1);
		apb(1'b1, IDX_COUNT, 8'h00);
		repeat (640) @(posedge pclk);
		rd(IDX_COUNT, 8'h00);
		i_src.level(1'b0);
		repeat (640) @(posedge pclk);
		apb(1'b0, IDX_COUNT, 8'h00);
		chk(8'(q >= 8'd9 && q <= 8'd11), 8'h01);
		apb(1'b1, IDX_CTRL, 8'h60);
		apb(1'b1, IDX_COUNT, 8'h00);
		repeat (640) @(posedge pclk);
		rd(IDX_COUNT, 8'h00);
		$display("test gated done");
		apb(1'b1, IDX_CTRL, 8'h00);
		apb(1'b1, IDX_MASK, 8'h80);
		apb(1'b1, IDX_FLAGS, 8'hf0);
		main_timer_wrap <= 1'b1;
		@(posedge pclk);
		main_timer_wrap <= 1'b0;
		repeat (3) @(posedge pclk);
		chk({7'h0, irq_req}, 8'h01);
		apb(1'b1, IDX_FLAGS, 8'h00);
		apb(1'b0, IDX_FLAGS, 8'h00);
		chk(q & 8'h80, 8'h80);
		apb(1'b1, IDX_FLAGS, 8'h80);
		apb(1'b0, IDX_FLAGS, 8'h00);
		chk(q & 8'h80, 8'h00);
		repeat (2) @(posedge pclk);
		chk({7'h0, irq_req}, 8'h00);
		$display("test overflow done");
		stop_test();
	end
endmodule
